// file: chbt_defs.svh
/*
  constants for the channel transfer master: register offsets, field
  positions, reset values and timing counts.
  assumes a 10 MHz clock and a 32-bit word-aligned register space.
*/
// Functional notes
// - cycle spans command strobe leading to trailing
// - memory/io select picks address space
// - multi-cycle hold signals more cycles follow
// - master drives address and qualifiers first
// - write asserts write status, read inactive
// - master asserts address latch strobe next
// - write data and parity before command
// - command asserts as address latch releases
// - cycle extends while ready is inactive
// - master may overlap next address and status
// - abort: no strobes, status pulse 85 ns
// - command leading edges 190 ns apart
// - command inactive 80 ns before next
// - status 55 ns before command
`ifndef CHBT_DEFS_SVH
`define CHBT_DEFS_SVH

// ***********************************************************
// register offsets
// ***********************************************************
`define CHBT_OFS_CTRL   8'h00
`define CHBT_OFS_ADDR   8'h04
`define CHBT_OFS_WDATA  8'h08
`define CHBT_OFS_RDATA  8'h0c
`define CHBT_OFS_STAT   8'h10

// ***********************************************************
// control fields
// ***********************************************************
`define CHBT_CTL_GO     0
`define CHBT_CTL_READ   1
`define CHBT_CTL_MEM    2
`define CHBT_CTL_ABORT  3
`define CHBT_CTL_HOLD   4
`define CHBT_CTL_A24    5
`define CHBT_CTL_APEN   6
`define CHBT_CTL_DPEN   7
`define CHBT_CTL_RST    32'h0000_0000

// ***********************************************************
// status fields
// ***********************************************************
`define CHBT_ST_BUSY    0
`define CHBT_ST_DONE    1
`define CHBT_ST_SEL     2
`define CHBT_ST_W16     3
`define CHBT_ST_W32     4
`define CHBT_ST_EXT     5
`define CHBT_ST_ABORTED 6
`define CHBT_ST_KIND    7

// ***********************************************************
// timing in ns and derived cycle counts
// ***********************************************************
`define CHBT_CLK_NS     100
`define CHBT_T_ADDR_NS  45
`define CHBT_T_STCMD_NS 55
`define CHBT_T_ADL_NS   40
`define CHBT_T_CMDW_NS  90
`define CHBT_T_CMDCMD_NS 190
`define CHBT_T_GAP_NS   80
`define CHBT_T_ABORT_NS 85
`define CHBT_T_SYNC_NS  30
`define CHBT_CYC(ns) (((ns) + `CHBT_CLK_NS - 1) / `CHBT_CLK_NS)
`define CHBT_N_ADDR   `CHBT_CYC(`CHBT_T_ADDR_NS)
`define CHBT_N_STCMD  `CHBT_CYC(`CHBT_T_STCMD_NS)
`define CHBT_N_ADL    `CHBT_CYC(`CHBT_T_ADL_NS)
`define CHBT_N_CMDW   `CHBT_CYC(`CHBT_T_CMDW_NS)
`define CHBT_N_CMDCMD `CHBT_CYC(`CHBT_T_CMDCMD_NS)
`define CHBT_N_GAP    `CHBT_CYC(`CHBT_T_GAP_NS)
`define CHBT_N_ABORT  `CHBT_CYC(`CHBT_T_ABORT_NS)
`define CHBT_N_SYNC   ((`CHBT_T_SYNC_NS) / `CHBT_CLK_NS + 1)

`endif

// file: chbt_pkg.sv
/*
  types for the channel transfer master.
  assumes chbt_defs.svh for numbers.
*/
package chbt_pkg;

  // ***********************************************************
  // channel pin groups
  // ***********************************************************
  typedef struct packed {
    logic [31:0] address;
    logic        addr_bit24_enable;
    logic        mem_io_select;
    logic        address_parity_enable_n;
    logic [3:0]  address_parity_bits;
    logic        write_status_line_n;
    logic        read_status_line_n;
    logic        address_latch_strobe_n;
    logic        command_strobe_n;
    logic        multi_cycle_hold_n;
    logic        data_parity_enable_n;
    logic [3:0]  data_parity_bits;
  } chbt_pins_t;

  typedef struct packed {
    logic card_select_feedback_n;
    logic port_width16_indicator_n;
    logic port_width32_indicator_n;
    logic card_ready_line;
  } chbt_resp_t;

  typedef struct packed {
    logic [31:0] haddr;
    logic        hwrite;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hsel;
    logic        hready;
  } chbt_ahb_t;

  typedef enum logic [6:0] {
    CHBT_IDLE  = 7'b000_0001,
    CHBT_ADDR  = 7'b000_0010,
    CHBT_STAT  = 7'b000_0100,
    CHBT_ADL   = 7'b000_1000,
    CHBT_CMD   = 7'b001_0000,
    CHBT_GAP   = 7'b010_0000,
    CHBT_ABORT = 7'b100_0000
  } chbt_state_t;

  typedef enum logic [1:0] {
    CHBT_DEFAULT = 2'h0,
    CHBT_SYNC    = 2'h1,
    CHBT_ASYNC   = 2'h2
  } chbt_kind_t;

  function automatic logic [3:0] chbt_parity(input logic [31:0] w);
    // odd parity per byte lane
    chbt_parity = {~^w[31:24], ~^w[23:16], ~^w[15:8], ~^w[7:0]};
  endfunction : chbt_parity

endpackage : chbt_pkg

// file: chbt_sync.sv
/*
  two-flop synchroniser for the slave response lines.
  assumes asynchronous active-low reset; reset value is idle (high).
*/
`timescale 1ns/100ps
module chbt_sync (
  input  wire logic             ref_clk_in,   // clock
  input  wire logic             rst_b_in,     // async reset, low
  input  wire chbt_pkg::chbt_resp_t d_in,     // raw pins
  output chbt_pkg::chbt_resp_t      q_out     // synchronised
);
  import chbt_pkg::*;

  typedef struct packed {
    chbt_resp_t s1;
    chbt_resp_t s2;
  } chbt_sync_st_t;

  chbt_sync_st_t st;
  chbt_sync_st_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = d_in;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign q_out = st.s2;

endmodule : chbt_sync

// file: chbt_master.sv
/*
  channel basic transfer master: AHB-Lite slave registers take orders,
  then a timed sequence of address, status, address latch and command
  strobes runs one default or extended cycle, or an abort.
  assumes one slave answering on the channel and a 10 MHz clock.
*/
`timescale 1ns/100ps
`include "chbt_defs.svh"
module chbt_master (
  input  wire logic                 ref_clk_in,   // 10 MHz clock
  input  wire logic                 rst_b_in,     // async reset, low
  input  wire logic                 hsel_in,      // ahb select
  input  wire logic [31:0]          haddr_in,     // ahb address
  input  wire logic [1:0]           htrans_in,    // ahb transfer type
  input  wire logic                 hwrite_in,    // ahb write
  input  wire logic [2:0]           hsize_in,     // ahb size
  input  wire logic [31:0]          hwdata_in,    // ahb write data
  input  wire logic                 hready_in,    // ahb ready
  output logic [31:0]               hrdata_out,   // ahb read data
  output logic                      hreadyout_out,// ahb ready out
  output logic                      hresp_out,    // ahb response
  output chbt_pkg::chbt_pins_t      pins_out,     // channel controls
  input  wire chbt_pkg::chbt_resp_t resp_in,      // slave responses
  input  wire logic [31:0]          data_in,      // data bus input
  output logic [31:0]               data_out,     // data bus output
  output logic                      data_oe_out   // data bus drive
);
  import chbt_pkg::*;

  typedef struct packed {
    chbt_state_t state;
    logic [31:0] ctrl;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        done;
    logic        aborted;
    logic        ext;
    chbt_kind_t  kind;
    logic [2:0]  fb;
    logic [3:0]  cnt;
    logic [3:0]  cmd_age;
    logic        ap_valid;
    logic        ap_write;
    logic [7:0]  ap_addr;
    logic [31:0] hrdata;
    chbt_pins_t  pins;
    logic [31:0] dout;
    logic        doe;
  } chbt_st_t;

  chbt_st_t   st;
  chbt_st_t   next_st;
  chbt_resp_t resp_s;
  logic       go;

  chbt_sync u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .d_in       (resp_in),
    .q_out      (resp_s)
  );

  function automatic chbt_pins_t idle_pins();
    chbt_pins_t p;
    p                          = '1;
    p.address                  = 32'h0000_0000;
    p.addr_bit24_enable        = 1'b0;
    p.mem_io_select            = 1'b0;
    p.address_parity_bits      = 4'h0;
    p.data_parity_bits         = 4'h0;
    idle_pins                  = p;
  endfunction : idle_pins

  function automatic logic [31:0] status_word(input chbt_st_t s);
    logic [31:0] w;
    w                          = 32'h0000_0000;
    w[`CHBT_ST_BUSY]           = (s.state != CHBT_IDLE);
    w[`CHBT_ST_DONE]           = s.done;
    w[`CHBT_ST_SEL]            = s.fb[0];
    w[`CHBT_ST_W16]            = s.fb[1];
    w[`CHBT_ST_W32]            = s.fb[2];
    w[`CHBT_ST_EXT]            = s.ext;
    w[`CHBT_ST_ABORTED]        = s.aborted;
    w[`CHBT_ST_KIND+1:`CHBT_ST_KIND] = s.kind;
    status_word                = w;
  endfunction : status_word

  assign go = st.ctrl[`CHBT_CTL_GO];

  always_comb begin
    next_st = st;
    // ***********************************************************
    // ahb-lite register slave, zero wait, always okay
    // ***********************************************************
    if (st.ap_valid && st.ap_write) begin
      unique case (st.ap_addr)
        `CHBT_OFS_CTRL: begin
          next_st.ctrl = hwdata_in;
        end
        `CHBT_OFS_ADDR: begin
          next_st.addr = hwdata_in;
        end
        `CHBT_OFS_WDATA: begin
          next_st.wdata = hwdata_in;
        end
        default: begin
        end
      endcase
      if (st.ap_addr == `CHBT_OFS_CTRL && hwdata_in[`CHBT_CTL_GO]) begin
        next_st.done = 1'b0;
      end
    end
    next_st.ap_valid = hsel_in && hready_in && htrans_in[1];
    next_st.ap_write = hwrite_in;
    next_st.ap_addr  = haddr_in[7:0];
    unique case (haddr_in[7:0])
      `CHBT_OFS_CTRL:  next_st.hrdata = st.ctrl;
      `CHBT_OFS_ADDR:  next_st.hrdata = st.addr;
      `CHBT_OFS_WDATA: next_st.hrdata = st.wdata;
      `CHBT_OFS_RDATA: next_st.hrdata = st.rdata;
      `CHBT_OFS_STAT:  next_st.hrdata = status_word(st);
      default:         next_st.hrdata = 32'h0000_0000;
    endcase

    // ***********************************************************
    // channel cycle sequencer
    // ***********************************************************
    if (st.cnt != 4'h0) begin
      next_st.cnt = st.cnt - 4'h1;
    end
    if (st.cmd_age != 4'hf) begin
      next_st.cmd_age = st.cmd_age + 4'h1;
    end
    unique case (st.state)
      CHBT_IDLE: begin
        if (go) begin
          next_st.ctrl[`CHBT_CTL_GO] = 1'b0;
          next_st.ext                = 1'b0;
          next_st.aborted            = 1'b0;
          next_st.kind               = CHBT_DEFAULT;
          next_st.fb                 = 3'h0;
          next_st.pins.address                 = st.addr;
          next_st.pins.addr_bit24_enable       = st.ctrl[`CHBT_CTL_A24];
          next_st.pins.mem_io_select           = st.ctrl[`CHBT_CTL_MEM];
          next_st.pins.address_parity_enable_n = ~st.ctrl[`CHBT_CTL_APEN];
          next_st.pins.address_parity_bits     = chbt_parity(st.addr);
          next_st.pins.multi_cycle_hold_n      = ~st.ctrl[`CHBT_CTL_HOLD];
          next_st.cnt   = 4'(`CHBT_N_ADDR);
          next_st.state = CHBT_ADDR;
        end
      end
      CHBT_ADDR: begin
        if (st.cnt <= 4'h1) begin
          next_st.pins.write_status_line_n = st.ctrl[`CHBT_CTL_READ];
          next_st.pins.read_status_line_n  = ~st.ctrl[`CHBT_CTL_READ];
          if (st.ctrl[`CHBT_CTL_ABORT]) begin
            next_st.cnt   = 4'(`CHBT_N_ABORT);
            next_st.state = CHBT_ABORT;
          end else begin
            next_st.cnt   = 4'(`CHBT_N_STCMD);
            next_st.state = CHBT_STAT;
          end
        end
      end
      CHBT_STAT: begin
        next_st.pins.address_latch_strobe_n = 1'b0;
        if (!st.ctrl[`CHBT_CTL_READ]) begin
          next_st.dout = st.wdata;
          next_st.doe  = 1'b1;
          next_st.pins.data_parity_enable_n = ~st.ctrl[`CHBT_CTL_DPEN];
          next_st.pins.data_parity_bits     = chbt_parity(st.wdata);
        end
        next_st.cnt   = 4'(`CHBT_N_ADL);
        next_st.state = CHBT_ADL;
      end
      CHBT_ADL: begin
        if (st.cnt <= 4'h1 && st.cmd_age >= 4'(`CHBT_N_CMDCMD - 1)) begin
          next_st.pins.address_latch_strobe_n = 1'b1;
          next_st.pins.command_strobe_n       = 1'b0;
          // feedback kept as seen when the command starts, not after deselect
          next_st.fb = {~resp_s.port_width32_indicator_n,
                        ~resp_s.port_width16_indicator_n,
                        ~resp_s.card_select_feedback_n};
          next_st.cmd_age = 4'h0;
          next_st.cnt     = 4'(`CHBT_N_CMDW);
          next_st.state   = CHBT_CMD;
        end
      end
      CHBT_CMD: begin
        if (!resp_s.card_ready_line) begin
          next_st.ext = 1'b1;
          // one extra cycle: ready lags a cycle behind the command edge
          next_st.kind = (st.cmd_age < 4'(`CHBT_N_SYNC + 1)) ? CHBT_SYNC : CHBT_ASYNC;
        end
        if (st.cnt <= 4'h1 && resp_s.card_ready_line) begin
          // cycle ends at command trailing edge
          if (st.ctrl[`CHBT_CTL_READ]) begin
            next_st.rdata = data_in;
          end
          // no overlap, status ends with command
          next_st.pins.command_strobe_n    = 1'b1;
          next_st.pins.write_status_line_n = 1'b1;
          next_st.pins.read_status_line_n  = 1'b1;
          next_st.cnt   = 4'(`CHBT_N_GAP);
          next_st.state = CHBT_GAP;
        end
      end
      CHBT_GAP: begin
        // write data held past trailing edge
        if (st.cnt <= 4'h1) begin
          next_st.doe   = 1'b0;
          next_st.pins  = idle_pins();
          next_st.pins.multi_cycle_hold_n = st.pins.multi_cycle_hold_n;
          next_st.done  = 1'b1;
          next_st.state = CHBT_IDLE;
        end
      end
      CHBT_ABORT: begin
        if (st.cnt <= 4'h1) begin
          // slave frees ready on status end
          next_st.pins    = idle_pins();
          next_st.aborted = 1'b1;
          next_st.done    = 1'b1;
          next_st.state   = CHBT_IDLE;
        end
      end
      default: begin
        next_st.pins  = idle_pins();
        next_st.doe   = 1'b0;
        next_st.state = CHBT_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st         <= '0;
      st.state   <= CHBT_IDLE;
      st.ctrl    <= `CHBT_CTL_RST;
      st.cmd_age <= 4'hf;
      st.pins    <= '1;
      st.pins.address             <= 32'h0000_0000;
      st.pins.addr_bit24_enable   <= 1'b0;
      st.pins.mem_io_select       <= 1'b0;
      st.pins.address_parity_bits <= 4'h0;
      st.pins.data_parity_bits    <= 4'h0;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata_out    = st.hrdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign pins_out      = st.pins;
  assign data_out      = st.dout;
  assign data_oe_out   = st.doe;

endmodule : chbt_master

// file: chbt_master_sva.sv
/* timing and order checks on the channel master pins.
   assumes the bind below; one clock, reset active low. */
`timescale 1ns/100ps
module chbt_master_sva (
  input wire logic                 ref_clk_in,  // clock
  input wire logic                 rst_b_in,    // reset, low
  input wire chbt_pkg::chbt_pins_t pins_out,    // channel controls
  input wire chbt_pkg::chbt_resp_t resp_in,     // slave replies
  input wire logic [31:0]          data_out,    // write data
  input wire logic                 data_oe_out  // data drive
);
  import chbt_pkg::*;
  // ******
  // helpers
  // ******
  logic st_act;
  logic cmd_n;
  assign st_act = !pins_out.write_status_line_n || !pins_out.read_status_line_n;
  assign cmd_n  = pins_out.command_strobe_n;
  function automatic logic [3:0] par4(input logic [31:0] w);
    par4 = {~^w[31:24], ~^w[23:16], ~^w[15:8], ~^w[7:0]};
  endfunction : par4
  default clocking dc @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  // ******
  // properties
  // ******
  property p_one_status;
    !(!pins_out.write_status_line_n && !pins_out.read_status_line_n);
  endproperty
  a_one_status: assert property (p_one_status)
    else $error("both status lines active");
  property p_adl_order;
    $fell(pins_out.address_latch_strobe_n) |-> st_act && $past(st_act);
  endproperty
  a_adl_order: assert property (p_adl_order)
    else $error("address latch without status");
  property p_cmd_swap;
    $fell(cmd_n) |-> $rose(pins_out.address_latch_strobe_n);
  endproperty
  a_cmd_swap: assert property (p_cmd_swap)
    else $error("command not paired with latch release");
  property p_status_lead;
    $fell(cmd_n) |-> $past(st_act, 2);
  endproperty
  a_status_lead: assert property (p_status_lead)
    else $error("command too soon after status");
  property p_cmd_gap;
    $fell(cmd_n) |-> $past(cmd_n, 2);
  endproperty
  a_cmd_gap: assert property (p_cmd_gap)
    else $error("command edges too close");
  property p_addr_held;
    $fell(cmd_n) |-> $stable(pins_out.address) && $stable(pins_out.mem_io_select);
  endproperty
  a_addr_held: assert property (p_addr_held)
    else $error("address moved before command");
  property p_apar;
    !pins_out.address_parity_enable_n |-> pins_out.address_parity_bits == par4(pins_out.address);
  endproperty
  a_apar: assert property (p_apar)
    else $error("address parity wrong");
  property p_wdata;
    !cmd_n && !pins_out.write_status_line_n |-> data_oe_out && $stable(data_out);
  endproperty
  a_wdata: assert property (p_wdata)
    else $error("write data not held in command");
  property p_dpar;
    !pins_out.data_parity_enable_n && data_oe_out |-> pins_out.data_parity_bits == par4(data_out);
  endproperty
  a_dpar: assert property (p_dpar)
    else $error("data parity wrong");
  property p_read_free;
    !pins_out.read_status_line_n |-> !data_oe_out;
  endproperty
  a_read_free: assert property (p_read_free)
    else $error("master drives data on read");
  property p_ready_end;
    $rose(cmd_n) |-> $past(resp_in.card_ready_line, 3);
  endproperty
  a_ready_end: assert property (p_ready_end)
    else $error("command ended while not ready");
  property p_abort_hold;
    $fell(st_act) && $past(cmd_n) |-> pins_out.multi_cycle_hold_n;
  endproperty
  a_abort_hold: assert property (p_abort_hold)
    else $error("hold kept after aborted status");
  c_ext: cover property ($rose(cmd_n) && !$past(resp_in.card_ready_line, 4));
  c_abort: cover property ($fell(st_act) && $past(cmd_n));
  c_read: cover property ($fell(cmd_n) && !pins_out.read_status_line_n);
endmodule : chbt_master_sva
bind chbt_master chbt_master_sva u_chbt_master_sva (.ref_clk_in, .rst_b_in, .pins_out,
  .resp_in, .data_out, .data_oe_out);

// file: chbt_slave_model.sv
/* behavioural slave adapter answering the channel master.
   assumes registered master pins; one storage word. */
`timescale 1ns/100ps
module chbt_slave_model #(
  parameter logic [15:0] BASE_HI = 16'h00c0  // decode window
) (
  input  wire logic                 ref_clk_in,  // clock
  input  wire logic                 rst_b_in,    // reset, low
  input  wire chbt_pkg::chbt_pins_t pins_in,     // master pins
  input  wire logic [3:0]           ext_in,      // wait length
  input  wire logic [31:0]          data_in,     // data bus
  output chbt_pkg::chbt_resp_t      resp_out,    // slave replies
  output logic [31:0]               data_out,    // read data
  output logic                      data_oe_out  // read drive
);
  import chbt_pkg::*;
  // ******
  // decode and replies
  // ******
  logic        sel, st_act, seen_q, sel_q, rd_q, cmd_q;
  logic [3:0]  cnt_q;
  logic [31:0] mem_q;
  assign sel = pins_in.mem_io_select && pins_in.addr_bit24_enable
               && pins_in.address[31:16] == BASE_HI;
  assign st_act = !pins_in.write_status_line_n || !pins_in.read_status_line_n;
  assign resp_out.card_select_feedback_n   = !sel;
  assign resp_out.port_width16_indicator_n = !sel;
  assign resp_out.port_width32_indicator_n = !(sel && !pins_in.address[8]);
  assign resp_out.card_ready_line = !((sel && st_act && !seen_q && ext_in != 4'h0)
                                      || (seen_q && cnt_q != 4'h0));
  assign data_oe_out = sel_q && rd_q && !pins_in.command_strobe_n;
  assign data_out    = mem_q;
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      {seen_q, sel_q, rd_q, cmd_q, cnt_q, mem_q} <= {4'h1, 4'h0, 32'h0};
    end else begin
      cmd_q <= pins_in.command_strobe_n;
      if ((!pins_in.address_latch_strobe_n || !pins_in.command_strobe_n) && !seen_q) begin
        // ready already low for one cycle before the latch
        {seen_q, sel_q, rd_q, cnt_q} <= {1'b1, sel, !pins_in.read_status_line_n,
                                         (ext_in == 4'h0) ? 4'h0 : ext_in - 4'h1};
      end else if (!pins_in.command_strobe_n && cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
      if (!cmd_q && pins_in.command_strobe_n && sel_q && !rd_q) begin
        mem_q <= data_in;
      end
      if (!st_act && pins_in.command_strobe_n) begin
        {seen_q, cnt_q} <= 5'h0;
      end
    end
  end
endmodule : chbt_slave_model

// file: tb.sv
/* self-checking bench: register calls drive channel cycles.
   assumes the slave model and the bound checker. */
`timescale 1ns/100ps
`include "chbt_defs.svh"
module tb;
  import chbt_pkg::*;
  logic        ref_clk_in, rst_b_in, hsel, hwrite, hready, hresp, m_oe, s_oe;
  logic [1:0]  htrans;
  logic [3:0]  ext;
  logic [31:0] haddr, hwdata, hrdata, rd, m_data, s_data, bus, bus_q;
  chbt_pins_t  pins;
  chbt_resp_t  resp;
  int          err_count, num_checks;
  // released bus shows the inverse of its last value
  assign bus = m_oe ? m_data : s_oe ? s_data : ~bus_q;
  always @(posedge ref_clk_in) bus_q <= bus;
  chbt_master u_chbt_master (.ref_clk_in, .rst_b_in, .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .pins_out(pins), .resp_in(resp), .data_in(bus), .data_out(m_data), .data_oe_out(m_oe));
  chbt_slave_model u_chbt_slave_model (.ref_clk_in, .rst_b_in, .pins_in(pins),
    .ext_in(ext), .data_in(bus), .resp_out(resp), .data_out(s_data), .data_oe_out(s_oe));
  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  // ******
  // tasks
  // ******
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %0s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic hwait;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      err_count++;
      finish_test();
    end
  endtask : hwait
  task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, ofs};
    hwait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    hwait();
    rd = hrdata;
  endtask : ahb
  task automatic run(input string nm, input logic [31:0] a, input logic [31:0] wd,
                     input logic [7:0] ctl, input logic [3:0] e, input logic [31:0] m,
                     input logic [31:0] st);
    int n;
    n = 0;
    ext <= e;
    ahb(1'b1, `CHBT_OFS_ADDR, a);
    ahb(1'b1, `CHBT_OFS_WDATA, wd);
    ahb(1'b1, `CHBT_OFS_CTRL, {24'h0, ctl});
    do begin
      ahb(1'b0, `CHBT_OFS_STAT, 32'h0);
      n++;
    end while (!(rd[0] === 1'b0 && (rd[1] | rd[6]) === 1'b1) && n < 40);
    if (rd[0] !== 1'b0) begin
      err_count++;
      finish_test();
    end
    chk(rd & m, st, nm);
    $display("test %0s done", nm);
  endtask : run
  // ******
  // sequence
  // ******
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, ext, bus_q} = '0;
    err_count = 0;
    num_checks = 0;
    rst_b_in = 1'b0;
    repeat (3) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    @(posedge ref_clk_in);
    chk({28'h0, pins.address_latch_strobe_n, pins.command_strobe_n,
         pins.write_status_line_n, pins.read_status_line_n}, 32'hf, "idle pins");
    ahb(1'b0, `CHBT_OFS_CTRL, 32'h0);
    chk(rd, `CHBT_CTL_RST, "ctrl reset");
    ahb(1'b0, `CHBT_OFS_STAT, 32'h0);
    chk(rd, 32'h0, "stat reset");
    ahb(1'b1, 8'h20, 32'hffff_ffff);
    ahb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0, "unmapped");
    run("wr32", 32'h00c0_0000, 32'ha5c3_0f1e, 8'he5, 4'h0, 32'h1ff, 32'h01e);
    chk(u_chbt_slave_model.mem_q, 32'ha5c3_0f1e, "slave word");
    run("rd32", 32'h00c0_0000, 32'h0, 8'he7, 4'h6, 32'h1ff, 32'h13e);
    ahb(1'b0, `CHBT_OFS_RDATA, 32'h0);
    chk(rd, 32'ha5c3_0f1e, "read word");
    run("wr16", 32'h00c0_0100, 32'h5a3c_f0e1, 8'he5, 4'h1, 32'h1ff, 32'h0ae);
    chk(u_chbt_slave_model.mem_q, 32'h5a3c_f0e1, "slave word16");
    run("io", 32'h00c0_0100, 32'h1234_5678, 8'he1, 4'h0, 32'h01f, 32'h002);
    chk(u_chbt_slave_model.mem_q, 32'h5a3c_f0e1, "io miss");
    run("abort", 32'h00c0_0000, 32'h0, 8'h3d, 4'h2, 32'h041, 32'h040);
    chk({31'h0, resp.card_ready_line}, 32'h1, "ready free");
    chk(u_chbt_slave_model.mem_q, 32'h5a3c_f0e1, "abort no write");
    finish_test();
  end
endmodule : tb
